// ### io_move_defines.svh
`ifndef IO_MOVE_DEFINES_SVH
`define IO_MOVE_DEFINES_SVH

// ==========================================================
// Memory map
`define WREG_BASE        7'h70
`define MEM_DEPTH        128

// ==========================================================
// Port C setup operand fields
`define PC_PULL_BIT      4
`define PC_DIR_MSB       3
`define PC_DIR_LSB       0

// ==========================================================
// Buzzer operand fields and tone codes
`define BZ_TONE_MSB      8
`define BZ_TONE_LSB      6
`define BZ_ENV_MSB       5
`define BZ_ENV_LSB       0
`define TONE_GEN         3'h7
`define TONE_HIGH        3'h4
`define TONE_4K          3'h3
`define TONE_2K          3'h2
`define TONE_1K          3'h1
`define TONE_LOW         3'h0
`define PHI_4K           3
`define PHI_2K           4
`define PHI_1K           5
`define PHI_ENV_FIRST    10

// ==========================================================
// Resistance-to-frequency control fields
`define RF_REF_BIT       0
`define RF_SENS_BIT      1
`define RF_CNT_BIT       3
`define RF_TMR2_BIT      4
`define RF_EXT_BIT       5

// ==========================================================
// Reset values
`define RST_NIBBLE       4'h0
`define RST_OPERAND      9'h000
`define RST_TONE         3'h0
`define RST_ENV          6'h00
`define RST_PULL_EN      1'b0

// ==========================================================
// Timing
`define CLK_HZ           125000000
`define BASE_HZ          32768
`define BASE_HALF_CYC    (`CLK_HZ / (2 * `BASE_HZ))
`define DIV_W            11
`define PHASE_W          16

`endif

// ### io_move_pkg.sv
package io_move_pkg;

  // ========================================================
  // Types
  typedef logic [3:0] nibble_t;
  typedef logic [6:0] mem_addr_t;

  typedef enum logic [4:0] {
    OP_NOP                 = 5'h00,
    OP_PORT_B_WRITE        = 5'h01,
    OP_PORT_B_READ         = 5'h02,
    OP_PORT_C_SETUP        = 5'h03,
    OP_PORT_C_WRITE        = 5'h04,
    OP_PORT_C_READ         = 5'h05,
    OP_BUZZER_SET_INSTR    = 5'h06,
    OP_RES_TONE_GENERATOR_OUTPUT_CTRL_INSTR = 5'h07,
    OP_MEM_TO_WORKREG_MOVE = 5'h08,
    OP_MEM_TO_INDEXED_MOVE = 5'h09,
    OP_WORKREG_TO_MEM_MOVE = 5'h0A,
    OP_INDEXED_TO_MEM_MOVE = 5'h0B,
    OP_SHIFT_RIGHT_ZERO    = 5'h0C,
    OP_SHIFT_RIGHT_ONE     = 5'h0D,
    OP_SHIFT_LEFT_ZERO     = 5'h0E,
    OP_SHIFT_LEFT_ONE      = 5'h0F,
    OP_BIT3_TO_CARRY       = 5'h10,
    OP_FLAGS_TO_MEM        = 5'h11
  } instr_op_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } exec_state_e;

endpackage : io_move_pkg

// ### ram_if.sv
`timescale 1ns/1ps

interface ram_if;
  import io_move_pkg::*;
  mem_addr_t rd_addr;
  nibble_t   rd_data;
  logic      we;
  mem_addr_t wr_addr;
  nibble_t   wr_data;

  modport exec (output rd_addr, input rd_data,
                output we, output wr_addr, output wr_data);
  modport mem  (input rd_addr, output rd_data,
                input we, input wr_addr, input wr_data);
endinterface : ram_if

// ### data_ram.sv
`timescale 1ns/1ps
`include "io_move_defines.svh"

module data_ram
  import io_move_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic ce_i,
  ram_if.mem        ram
);

  // ========================================================
  // Storage, no reset: contents start unknown
  nibble_t mem_array [`MEM_DEPTH];

  always_ff @(posedge clock_i) begin
    if (ce_i && ram.we) begin
      mem_array[ram.wr_addr] <= ram.wr_data;
    end
  end

  assign ram.rd_data = mem_array[ram.rd_addr];

endmodule : data_ram

// ### buzzer_gen.sv
`timescale 1ns/1ps
`include "io_move_defines.svh"

module buzzer_gen
  import io_move_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic [2:0] tone_sel_i,
  input  wire logic [5:0] env_en_i,
  input  wire logic       tone_generator_output_i,
  output logic            buzzer_out_o,
  output logic            buzzer_out_inverted_o
);
  localparam logic [`DIV_W-1:0] HALF_LAST =
    `DIV_W'(`BASE_HALF_CYC - 1);

  logic [`DIV_W-1:0]   div_reg;
  logic [`DIV_W-1:0]   div_next;
  logic [`PHASE_W-1:0] phase_reg;
  logic [`PHASE_W-1:0] phase_next;
  logic                bz_reg;
  logic                bz_next;
  logic [5:0]          env_term;
  logic                tone;
  logic                env;

  // ========================================================
  // Envelope taps
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_env
      assign env_term[gi] = env_en_i[gi] &
                            phase_reg[`PHI_ENV_FIRST + gi];
    end
  endgenerate

  // ========================================================
  // Divider and output
  always_comb begin
    div_next   = div_reg;
    phase_next = phase_reg;
    if (div_reg == HALF_LAST) begin
      div_next   = '0;
      phase_next = phase_reg + `PHASE_W'(1);
    end else begin
      div_next   = div_reg + `DIV_W'(1);
    end
    unique case (tone_sel_i)
      `TONE_GEN:  tone = tone_generator_output_i;
      `TONE_HIGH: tone = 1'b1;
      `TONE_4K:   tone = phase_reg[`PHI_4K];
      `TONE_2K:   tone = phase_reg[`PHI_2K];
      `TONE_1K:   tone = phase_reg[`PHI_1K];
      default:    tone = 1'b0;
    endcase
    env     = (env_en_i == 6'h00) ? 1'b1 : (|env_term);
    bz_next = tone & env;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg   <= '0;
      phase_reg <= '0;
      bz_reg    <= 1'b0;
      buzzer_out_inverted_o <= 1'b1;
    end else if (ce_i) begin
      div_reg   <= div_next;
      phase_reg <= phase_next;
      bz_reg    <= bz_next;
      buzzer_out_inverted_o <= ~bz_next;
    end
  end

  assign buzzer_out_o          = bz_reg;

endmodule : buzzer_gen

// ### io_and_move_instr_exec.sv
`timescale 1ns/1ps
`include "io_move_defines.svh"

// What this block does
// - Port write copies memory nibble to latch
// - Port read stores pins to sum, memory
// - Setup bit4 swaps pull-low and hold devices
// - Setup bits3..0 set pins 4..1 direction
// - Pull-low acts only on input pins
// - Buzzer bits8..6 select tone source
// - Buzzer bits5..0 enable envelopes, combined
// - Frequencies divided from 32768Hz base
// - Bits0,1 enable reference, sensor networks
// - Bit3 enables the 16-bit counter
// - Bit4 gives counter gating to timer2
// - Bit5 gates counter from external pin
// - Memory nibble to sum and working register
// - Memory nibble to sum and indexed location
// - Working register to sum and memory
// - Indexed location to sum and memory
// - Right shift inserts 0/1 at bit3
// - Left shift inserts 0/1 at bit0
// - Bit3 of memory into carry only
// - Carry, zero flags into sum and memory
// - Working register index maps to 70H+index

module io_and_move_instr_exec
  import io_move_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       instr_valid_i,
  input  instr_op_e       instr_op_i,
  input  wire logic [6:0] rx_addr_i,
  input  wire logic [3:0] working_register_index_i,
  input  wire logic [6:0] indexed_pointer_i,
  input  wire logic [8:0] operand_i,
  input  wire logic [3:0] port_b_pins_i,
  input  wire logic [3:0] port_c_pins_i,
  input  wire logic       tone_generator_output_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [3:0]      working_sum_register_o,
  output logic            carry_flag_o,
  output logic [3:0]      port_b_out_o,
  output logic [3:0]      port_c_out_o,
  output logic [3:0]      port_c_oe_o,
  output logic [3:0]      port_c_pull_low_o,
  output logic [3:0]      port_c_low_hold_o,
  output logic            buzzer_out_o,
  output logic            buzzer_out_inverted_o,
  output logic            ref_resistor_pin_en_o,
  output logic            sensor_resistor_pin_en_o,
  output logic            rfc_counter_en_o,
  output logic            rfc_timer2_gate_o,
  output logic            rfc_external_count_gate_o
);

  // ========================================================
  // State
  exec_state_e state_reg;
  exec_state_e state_next;
  instr_op_e   op_reg;
  instr_op_e   op_next;
  logic [8:0]  opnd_reg;
  logic [8:0]  opnd_next;
  mem_addr_t   src_reg;
  mem_addr_t   src_next;
  mem_addr_t   dst_reg;
  mem_addr_t   dst_next;
  nibble_t     acc_reg;
  nibble_t     acc_next;
  logic        carry_reg;
  logic        carry_next;
  logic        done_reg;
  logic        done_next;
  logic        busy_reg;
  logic        busy_next;
  nibble_t     pb_reg;
  nibble_t     pb_next;
  nibble_t     pc_out_reg;
  nibble_t     pc_out_next;
  nibble_t     pc_dir_reg;
  nibble_t     pc_dir_next;
  logic        pull_en_reg;
  logic        pull_en_next;
  nibble_t     pull_eff_reg;
  nibble_t     pull_eff_next;
  nibble_t     hold_eff_reg;
  nibble_t     hold_eff_next;
  logic [2:0]  tone_reg;
  logic [2:0]  tone_next;
  logic [5:0]  env_reg;
  logic [5:0]  env_next;
  logic [4:0]  rf_reg;
  logic [4:0]  rf_next;
  mem_addr_t   wreg_addr;
  nibble_t     rd_val;
  nibble_t     wr_val;
  logic        wr_en;
  logic        zero_flag;

  ram_if ram ();

  // ========================================================
  // Address forming
  // index plus 70H
  assign wreg_addr = 7'(`WREG_BASE + {3'h0, working_register_index_i});
  assign rd_val    = ram.rd_data;
  assign zero_flag = (acc_reg == 4'h0);

  // ========================================================
  // Sequencer and execution
  always_comb begin
    state_next    = state_reg;
    op_next       = op_reg;
    opnd_next     = opnd_reg;
    src_next      = src_reg;
    dst_next      = dst_reg;
    acc_next      = acc_reg;
    carry_next    = carry_reg;
    pb_next       = pb_reg;
    pc_out_next   = pc_out_reg;
    pc_dir_next   = pc_dir_reg;
    pull_en_next  = pull_en_reg;
    tone_next     = tone_reg;
    env_next      = env_reg;
    rf_next       = rf_reg;
    done_next     = 1'b0;
    wr_en         = 1'b0;
    wr_val        = 4'h0;
    unique case (state_reg)
      ST_IDLE: begin
        if (instr_valid_i) begin
          op_next    = instr_op_i;
          opnd_next  = operand_i;
          src_next   = rx_addr_i;
          dst_next   = rx_addr_i;
          state_next = ST_EXEC;
          unique case (instr_op_i)
            OP_MEM_TO_WORKREG_MOVE: dst_next = wreg_addr;
            OP_MEM_TO_INDEXED_MOVE: dst_next = indexed_pointer_i;
            OP_WORKREG_TO_MEM_MOVE: src_next = wreg_addr;
            OP_INDEXED_TO_MEM_MOVE: src_next = indexed_pointer_i;
            default: begin
            end
          endcase
        end
      end
      ST_EXEC: begin
        state_next = ST_IDLE;
        done_next  = 1'b1;
        unique case (op_reg)
          OP_PORT_B_WRITE: pb_next     = rd_val;
          OP_PORT_C_WRITE: pc_out_next = rd_val;
          OP_PORT_B_READ: begin
            wr_en    = 1'b1;
            wr_val   = port_b_pins_i;
            acc_next = port_b_pins_i;
          end
          OP_PORT_C_READ: begin
            wr_en    = 1'b1;
            wr_val   = port_c_pins_i;
            acc_next = port_c_pins_i;
          end
          OP_PORT_C_SETUP: begin
            pull_en_next = opnd_reg[`PC_PULL_BIT];
            pc_dir_next  = opnd_reg[`PC_DIR_MSB:`PC_DIR_LSB];
          end
          OP_BUZZER_SET_INSTR: begin
            tone_next = opnd_reg[`BZ_TONE_MSB:`BZ_TONE_LSB];
            env_next  = opnd_reg[`BZ_ENV_MSB:`BZ_ENV_LSB];
          end
          OP_RES_TONE_GENERATOR_OUTPUT_CTRL_INSTR: begin
            rf_next[0] = opnd_reg[`RF_REF_BIT];
            rf_next[1] = opnd_reg[`RF_SENS_BIT];
            rf_next[2] = opnd_reg[`RF_CNT_BIT];
            rf_next[3] = opnd_reg[`RF_TMR2_BIT];
            rf_next[4] = opnd_reg[`RF_EXT_BIT];
          end
          OP_MEM_TO_WORKREG_MOVE,
          OP_MEM_TO_INDEXED_MOVE,
          OP_WORKREG_TO_MEM_MOVE,
          OP_INDEXED_TO_MEM_MOVE: begin
            wr_en    = 1'b1;
            wr_val   = rd_val;
            acc_next = rd_val;
          end
          OP_SHIFT_RIGHT_ZERO,
          OP_SHIFT_RIGHT_ONE: begin
            wr_en    = 1'b1;
            wr_val   = {op_reg == OP_SHIFT_RIGHT_ONE, rd_val[3:1]};
            acc_next = wr_val;
          end
          OP_SHIFT_LEFT_ZERO,
          OP_SHIFT_LEFT_ONE: begin
            wr_en    = 1'b1;
            wr_val   = {rd_val[2:0], op_reg == OP_SHIFT_LEFT_ONE};
            acc_next = wr_val;
          end
          OP_BIT3_TO_CARRY: carry_next = rd_val[3];
          OP_FLAGS_TO_MEM: begin
            wr_en    = 1'b1;
            wr_val   = {carry_reg, zero_flag, 2'b00};
            acc_next = wr_val;
          end
          default: begin
          end
        endcase
      end
    endcase
    busy_next     = (state_next == ST_EXEC);
    pull_eff_next = pull_en_next ? ~pc_dir_next : 4'h0;
    // Hold devices gated the same way, never fight a driver
    hold_eff_next = pull_en_next ? 4'h0 : ~pc_dir_next;
  end

  always_comb begin
    ram.rd_addr = src_reg;
    ram.we      = wr_en;
    ram.wr_addr = dst_reg;
    ram.wr_data = wr_val;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg    <= ST_IDLE;
      op_reg       <= OP_NOP;
      opnd_reg     <= `RST_OPERAND;
      src_reg      <= '0;
      dst_reg      <= '0;
      acc_reg      <= `RST_NIBBLE;
      carry_reg    <= 1'b0;
      done_reg     <= 1'b0;
      busy_reg     <= 1'b0;
      pb_reg       <= `RST_NIBBLE;
      pc_out_reg   <= `RST_NIBBLE;
      pc_dir_reg   <= `RST_NIBBLE;
      pull_en_reg  <= `RST_PULL_EN;
      pull_eff_reg <= `RST_NIBBLE;
      hold_eff_reg <= 4'hF;
      tone_reg     <= `RST_TONE;
      env_reg      <= `RST_ENV;
      rf_reg       <= '0;
    end else if (ce_i) begin
      state_reg    <= state_next;
      op_reg       <= op_next;
      opnd_reg     <= opnd_next;
      src_reg      <= src_next;
      dst_reg      <= dst_next;
      acc_reg      <= acc_next;
      carry_reg    <= carry_next;
      done_reg     <= done_next;
      busy_reg     <= busy_next;
      pb_reg       <= pb_next;
      pc_out_reg   <= pc_out_next;
      pc_dir_reg   <= pc_dir_next;
      pull_en_reg  <= pull_en_next;
      pull_eff_reg <= pull_eff_next;
      hold_eff_reg <= hold_eff_next;
      tone_reg     <= tone_next;
      env_reg      <= env_next;
      rf_reg       <= rf_next;
    end
  end

  // ========================================================
  // Sub-blocks
  data_ram u_data_ram (
    .clock_i (clock_i),
    .ce_i    (ce_i),
    .ram     (ram.mem)
  );

  buzzer_gen u_buzzer_gen (
    .clock_i                 (clock_i),
    .rst_n_i                 (rst_n_i),
    .ce_i                    (ce_i),
    .tone_sel_i              (tone_reg),
    .env_en_i                (env_reg),
    .tone_generator_output_i (tone_generator_output_i),
    .buzzer_out_o            (buzzer_out_o),
    .buzzer_out_inverted_o   (buzzer_out_inverted_o)
  );

  // ========================================================
  // Outputs
  assign busy_o                    = busy_reg;
  assign done_o                    = done_reg;
  assign working_sum_register_o    = acc_reg;
  assign carry_flag_o              = carry_reg;
  assign port_b_out_o              = pb_reg;
  assign port_c_out_o              = pc_out_reg;
  assign port_c_oe_o               = pc_dir_reg;
  assign port_c_pull_low_o         = pull_eff_reg;
  assign port_c_low_hold_o         = hold_eff_reg;
  // Gate bits passed as written; both set is not resolved here
  assign ref_resistor_pin_en_o     = rf_reg[0];
  assign sensor_resistor_pin_en_o  = rf_reg[1];
  assign rfc_counter_en_o          = rf_reg[2];
  assign rfc_timer2_gate_o         = rf_reg[3];
  assign rfc_external_count_gate_o = rf_reg[4];

endmodule : io_and_move_instr_exec

// ### io_and_move_instr_exec_props.sv
`timescale 1ns/1ps

module io_and_move_instr_exec_props
  import io_move_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  input wire logic       ce_i,
  input wire logic       instr_valid_i,
  input instr_op_e       instr_op_i,
  input wire logic [8:0] operand_i,
  input wire logic [3:0] port_b_pins_i,
  input wire logic       busy_o,
  input wire logic       done_o,
  input wire logic [3:0] working_sum_register_o,
  input wire logic       carry_flag_o,
  input wire logic [3:0] port_c_oe_o,
  input wire logic [3:0] port_c_pull_low_o,
  input wire logic [3:0] port_c_low_hold_o,
  input wire logic       buzzer_out_o,
  input wire logic       buzzer_out_inverted_o,
  input wire logic       ref_resistor_pin_en_o,
  input wire logic       sensor_resistor_pin_en_o,
  input wire logic       rfc_counter_en_o,
  input wire logic       rfc_timer2_gate_o,
  input wire logic       rfc_external_count_gate_o
);
  // ==========================================================
  // Op tracking
  // Two stages, so a back-to-back take cannot replace the judged op
  instr_op_e  op_reg, op_next, xop_reg, xop_next;
  logic [8:0] opd_reg, opd_next, xopd_reg, xopd_next;

  always_comb begin
    op_next   = op_reg;
    opd_next  = opd_reg;
    xop_next  = xop_reg;
    xopd_next = xopd_reg;
    if (ce_i && instr_valid_i && !busy_o) begin
      op_next  = instr_op_i;
      opd_next = operand_i;
    end
    if (ce_i && busy_o) begin
      xop_next  = op_reg;
      xopd_next = opd_reg;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_reg   <= OP_NOP;
      opd_reg  <= 9'h000;
      xop_reg  <= OP_NOP;
      xopd_reg <= 9'h000;
    end else begin
      op_reg   <= op_next;
      opd_reg  <= opd_next;
      xop_reg  <= xop_next;
      xopd_reg <= xopd_next;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_take;
    ce_i && instr_valid_i && !busy_o |=> busy_o;
  endproperty
  a_take: assert property (p_take) else $error("request not taken");

  property p_done;
    ce_i && busy_o |=> done_o && !busy_o ##1 !done_o;
  endproperty
  a_done: assert property (p_done) else $error("done not one pulse");

  property p_read;
    done_o && xop_reg == OP_PORT_B_READ
      |-> working_sum_register_o == $past(port_b_pins_i);
  endproperty
  a_read: assert property (p_read) else $error("pin read wrong");

  property p_inv;
    buzzer_out_inverted_o == !buzzer_out_o;
  endproperty
  a_inv: assert property (p_inv) else $error("buzzer pair");

  property p_pull;
    (port_c_pull_low_o & port_c_oe_o) == 4'h0;
  endproperty
  a_pull: assert property (p_pull) else $error("pull on output");

  property p_setup;
    done_o && xop_reg == OP_PORT_C_SETUP |-> port_c_oe_o == xopd_reg[3:0]
      && port_c_pull_low_o == (xopd_reg[4] ? ~xopd_reg[3:0] : 4'h0)
      && port_c_low_hold_o == (xopd_reg[4] ? 4'h0 : ~xopd_reg[3:0]);
  endproperty
  a_setup: assert property (p_setup) else $error("setup");

  property p_rfc;
    done_o && xop_reg == OP_RES_TONE_GENERATOR_OUTPUT_CTRL_INSTR
      |-> {rfc_external_count_gate_o, rfc_timer2_gate_o, rfc_counter_en_o,
           sensor_resistor_pin_en_o, ref_resistor_pin_en_o}
          == {xopd_reg[5:3], xopd_reg[1:0]};
  endproperty
  a_rfc: assert property (p_rfc) else $error("rfc");

  property p_carry;
    !(done_o && xop_reg == OP_BIT3_TO_CARRY) |-> $stable(carry_flag_o);
  endproperty
  a_carry: assert property (p_carry) else $error("carry");

  property p_steady;
    done_o && xop_reg == OP_BUZZER_SET_INSTR && xopd_reg[5:0] == 6'h00
      && (xopd_reg[8:6] == 3'h4 || xopd_reg[8:6] == 3'h0)
      |=> buzzer_out_o == $past(xopd_reg[8]);
  endproperty
  a_steady: assert property (p_steady) else $error("steady");
endmodule : io_and_move_instr_exec_props

// ### pin_model.sv
`timescale 1ns/1ps

module pin_model (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] ext_b_i,
  input  wire logic [3:0] ext_c_i,
  input  wire logic [3:0] port_c_out_i,
  input  wire logic [3:0] port_c_oe_i,
  output logic      [3:0] port_b_pins_o,
  output logic      [3:0] port_c_pins_o,
  output logic            tone_o
);
  // ==========================================================
  // Pins
  logic [1:0] div_reg;
  assign port_b_pins_o = ext_b_i;
  assign port_c_pins_o = (port_c_oe_i & port_c_out_i) |
                         (~port_c_oe_i & ext_c_i);
  assign tone_o        = div_reg[1];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
endmodule : pin_model

// ### io_and_move_instr_exec_bench.sv
`timescale 1ns/1ps
`include "io_move_defines.svh"

module io_and_move_instr_exec_bench
  import io_move_pkg::*;
;
  // ==========================================================
  // Signals
  logic       clock_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
  logic       instr_valid_i = 1'b0;
  instr_op_e  instr_op_i = OP_NOP;
  logic [6:0] rx_addr_i = 7'h00, indexed_pointer_i = 7'h00;
  logic [3:0] working_register_index_i = 4'h0, ext_b = 4'h0, ext_c = 4'h0;
  logic [8:0] operand_i = 9'h000;
  logic [3:0] port_b_pins_i, port_c_pins_i, working_sum_register_o;
  logic [3:0] port_b_out_o, port_c_out_o, port_c_oe_o;
  logic [3:0] port_c_pull_low_o, port_c_low_hold_o;
  logic       tone_generator_output_i, busy_o, done_o, carry_flag_o;
  logic       buzzer_out_o, buzzer_out_inverted_o, ref_resistor_pin_en_o;
  logic       sensor_resistor_pin_en_o, rfc_counter_en_o;
  logic       rfc_timer2_gate_o, rfc_external_count_gate_o;
  wire  [4:0] rfc_bits = {rfc_external_count_gate_o, rfc_timer2_gate_o,
                          rfc_counter_en_o, sensor_resistor_pin_en_o,
                          ref_resistor_pin_en_o};
  int         checks = 0, miscompares = 0;

  always #4 clock_i = ~clock_i;

  io_and_move_instr_exec dut (.clock_i, .rst_n_i, .ce_i, .instr_valid_i,
    .instr_op_i, .rx_addr_i, .working_register_index_i, .indexed_pointer_i,
    .operand_i, .port_b_pins_i, .port_c_pins_i, .tone_generator_output_i,
    .busy_o, .done_o, .working_sum_register_o, .carry_flag_o, .port_b_out_o,
    .port_c_out_o, .port_c_oe_o, .port_c_pull_low_o, .port_c_low_hold_o,
    .buzzer_out_o, .buzzer_out_inverted_o, .ref_resistor_pin_en_o,
    .sensor_resistor_pin_en_o, .rfc_counter_en_o, .rfc_timer2_gate_o,
    .rfc_external_count_gate_o);

  pin_model pins (.clock_i, .rst_n_i, .ext_b_i(ext_b), .ext_c_i(ext_c),
    .port_c_out_i(port_c_out_o), .port_c_oe_i(port_c_oe_o),
    .port_b_pins_o(port_b_pins_i), .port_c_pins_o(port_c_pins_i),
    .tone_o(tone_generator_output_i));

  // ==========================================================
  // Helpers
  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Fields stay up after the take; only valid drops
  task automatic exec(input instr_op_e op, input logic [6:0] rx,
                      input logic [3:0] idx, input logic [6:0] hl,
                      input logic [8:0] opd);
    int n;
    @(posedge clock_i);
    instr_valid_i            <= 1'b1;
    instr_op_i               <= op;
    rx_addr_i                <= rx;
    working_register_index_i <= idx;
    indexed_pointer_i        <= hl;
    operand_i                <= opd;
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 8);
    if (n >= 8) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : exec

  task automatic load(input logic [6:0] rx, input logic [3:0] v);
    @(posedge clock_i);
    ext_b <= v;
    exec(OP_PORT_B_READ, rx, 4'h0, 7'h00, 9'h000);
  endtask : load

  task automatic wr_chk(input logic [6:0] rx, input logic [3:0] v);
    exec(OP_PORT_B_WRITE, rx, 4'h0, 7'h00, 9'h000);
    chk(port_b_out_o, v);
  endtask : wr_chk

  // ==========================================================
  // Scenarios
  task automatic t_port_b();
    chk({port_c_low_hold_o, port_c_oe_o, working_sum_register_o}, 16'h0F00);
    chk({buzzer_out_o, buzzer_out_inverted_o, carry_flag_o}, 16'h0002);
    load(7'h05, 4'hA);
    chk(working_sum_register_o, 4'hA);
    wr_chk(7'h05, 4'hA);
    exec(OP_MEM_TO_WORKREG_MOVE, 7'h05, 4'h3, 7'h00, 9'h000);
    chk(working_sum_register_o, 4'hA);
    load(7'h11, 4'h5);
    load(7'h20, 4'h6);
    wr_chk(7'h20, 4'h6);
    wr_chk(7'h73, 4'hA);
    exec(OP_WORKREG_TO_MEM_MOVE, 7'h11, 4'h3, 7'h00, 9'h000);
    chk(working_sum_register_o, 4'hA);
    wr_chk(7'h11, 4'hA);
    exec(OP_MEM_TO_INDEXED_MOVE, 7'h20, 4'h0, 7'h30, 9'h000);
    chk(working_sum_register_o, 4'h6);
    load(7'h31, 4'h9);
    exec(OP_INDEXED_TO_MEM_MOVE, 7'h31, 4'h0, 7'h30, 9'h000);
    chk(working_sum_register_o, 4'h6);
    wr_chk(7'h31, 4'h6);
    chk(carry_flag_o, 1'b0);
    $display("moves done");
  endtask : t_port_b

  task automatic t_shift_flags();
    instr_op_e  sop [4] = '{OP_SHIFT_RIGHT_ZERO, OP_SHIFT_RIGHT_ONE,
                            OP_SHIFT_LEFT_ZERO, OP_SHIFT_LEFT_ONE};
    logic [3:0] sexp [4] = '{4'h4, 4'hC, 4'h2, 4'h3};
    for (int i = 0; i < 4; i++) begin
      load(7'h40, 4'h9);
      exec(sop[i], 7'h40, 4'h0, 7'h00, 9'h000);
      chk(working_sum_register_o, sexp[i]);
      wr_chk(7'h40, sexp[i]);
    end
    load(7'h41, 4'h8);
    exec(OP_BIT3_TO_CARRY, 7'h41, 4'h0, 7'h00, 9'h000);
    chk({carry_flag_o, working_sum_register_o}, 16'h0018);
    load(7'h42, 4'h0);
    chk(carry_flag_o, 1'b1);
    exec(OP_FLAGS_TO_MEM, 7'h42, 4'h0, 7'h00, 9'h000);
    chk(working_sum_register_o, 4'hC);
    wr_chk(7'h42, 4'hC);
    load(7'h43, 4'h7);
    exec(OP_BIT3_TO_CARRY, 7'h43, 4'h0, 7'h00, 9'h000);
    exec(OP_FLAGS_TO_MEM, 7'h43, 4'h0, 7'h00, 9'h000);
    chk(working_sum_register_o, 4'h0);
    $display("shift and flags done");
  endtask : t_shift_flags

  task automatic t_port_c();
    exec(OP_PORT_C_SETUP, 7'h00, 4'h0, 7'h00, 9'h013);
    chk({port_c_low_hold_o, port_c_pull_low_o, port_c_oe_o}, 16'h0C3);
    exec(OP_PORT_C_WRITE, 7'h05, 4'h0, 7'h00, 9'h000);
    chk(port_c_out_o, 4'hA);
    @(posedge clock_i);
    ext_c <= 4'hF;
    exec(OP_PORT_C_READ, 7'h50, 4'h0, 7'h00, 9'h000);
    chk(working_sum_register_o, 4'hE);
    wr_chk(7'h50, 4'hE);
    exec(OP_PORT_C_SETUP, 7'h00, 4'h0, 7'h00, 9'h00C);
    chk({port_c_low_hold_o, port_c_pull_low_o, port_c_oe_o}, 16'h30C);
    $display("port c done");
  endtask : t_port_c

  task automatic t_buzzer();
    logic [8:0] opd [4] = '{9'h100, 9'h000, 9'h101, 9'h120};
    logic       exp [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    logic       t;
    int         n;
    // Envelopes start low, so early gating must silence the tone
    for (int i = 0; i < 4; i++) begin
      exec(OP_BUZZER_SET_INSTR, 7'h00, 4'h0, 7'h00, opd[i]);
      @(posedge clock_i);
      #1;
      chk({buzzer_out_o, buzzer_out_inverted_o}, {exp[i], ~exp[i]});
    end
    exec(OP_BUZZER_SET_INSTR, 7'h00, 4'h0, 7'h00, 9'h1C0);
    for (int i = 0; i < 8; i++) begin
      t = tone_generator_output_i;
      @(posedge clock_i);
      #1;
      chk(buzzer_out_o, t);
    end
    exec(OP_BUZZER_SET_INSTR, 7'h00, 4'h0, 7'h00, 9'h0C0);
    for (int k = 0; k < 3; k++) begin
      t = buzzer_out_o;
      n = 0;
      while (buzzer_out_o === t && n < 20000) begin
        @(posedge clock_i);
        #1;
        n++;
      end
    end
    chk(n[15:0], 16'(`BASE_HALF_CYC * 8));
    $display("buzzer done");
  endtask : t_buzzer

  task automatic t_rfc();
    logic [8:0] opd [6] = '{9'h001, 9'h002, 9'h008, 9'h018, 9'h028, 9'h000};
    logic [4:0] exp [6] = '{5'h01, 5'h02, 5'h04, 5'h0C, 5'h14, 5'h00};
    for (int i = 0; i < 6; i++) begin
      exec(OP_RES_TONE_GENERATOR_OUTPUT_CTRL_INSTR, 7'h00, 4'h0, 7'h00, opd[i]);
      chk(rfc_bits, exp[i]);
    end
    $display("rfc done");
  endtask : t_rfc

  initial begin
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    t_port_b();
    t_shift_flags();
    t_port_c();
    t_rfc();
    t_buzzer();
    tally_and_finish();
  end
endmodule : io_and_move_instr_exec_bench

bind io_and_move_instr_exec io_and_move_instr_exec_props props (
  .clock_i, .rst_n_i, .ce_i, .instr_valid_i, .instr_op_i, .operand_i,
  .port_b_pins_i, .busy_o, .done_o, .working_sum_register_o,
  .carry_flag_o, .port_c_oe_o, .port_c_pull_low_o, .port_c_low_hold_o,
  .buzzer_out_o, .buzzer_out_inverted_o, .ref_resistor_pin_en_o,
  .sensor_resistor_pin_en_o, .rfc_counter_en_o, .rfc_timer2_gate_o,
  .rfc_external_count_gate_o);
